// ===== logic/tdcgc_map.vh
/*
  register offsets, field positions, reset values and timing counts of the
  tdc general configuration and interrupt block.
  assumes a 20 MHz sys_clk and a plain strobe register port.
*/
// Behaviour
// - predivider code 0 passes, 1 halves, 2 quarters the high-speed clock.
// - oscillator off, on, or switched on with 480us/1.46/2.44/5.14ms settle.
// - reference 2 to 8 MHz, default 4 MHz; host must know it. the code assumes a fixed 20 MHz reference.
// - low-frequency oscillator current option, low saves power, high starts.
// - start-noise control injects noise into the start channel.
// - phase-noise disable switches the phase-noise generator off.
// - auto re-init performs init after each interrupt without host command.
// - on timeout with error fill set, result becomes all ones.
// - fourfold resolution only permitted in measure mode 2.
// - twofold resolution usable in measure mode 1 and 2.
// - each interrupt source reaches the output only when enabled.
// - timeout of the measurement unit raises an interrupt if enabled.
// - expected number of stop hits reached raises an interrupt if enabled.
// - arithmetic unit done raises an interrupt; host enables it for multi-hit.
// - completed nonvolatile memory transfer raises an interrupt if enabled.
// - nonvolatile memory of seven 32-bit words holds config and ident.
// - stored ident fields can be read back by the host.
`ifndef TDCGC_MAP_VH
`define TDCGC_MAP_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TDCGC_CFG_ADDR 8'h00
`define TDCGC_IRQEN_ADDR 8'h04
`define TDCGC_STAT_ADDR 8'h08
`define TDCGC_RESULT_ADDR 8'h0c
`define TDCGC_CMD_ADDR 8'h10
`define TDCGC_NVSEL_ADDR 8'h14
`define TDCGC_NVDATA_ADDR 8'h18
// ---------------------------------------------------------------
// configuration fields
// ---------------------------------------------------------------
`define TDCGC_DIV_LSB 0
`define TDCGC_START_LSB 2
`define TDCGC_LFHIGH_BIT 5
`define TDCGC_NOISE_BIT 6
`define TDCGC_PHDIS_BIT 7
`define TDCGC_REINIT_BIT 8
`define TDCGC_ERRFILL_BIT 9
`define TDCGC_QUAD_BIT 10
`define TDCGC_DOUBLE_BIT 11
`define TDCGC_MODE2_BIT 12
`define TDCGC_CFG_RESET 13'h0000
`define TDCGC_CFG_W 13
// command bits
`define TDCGC_CMD_INIT_BIT 0
`define TDCGC_CMD_NVWR_BIT 1
`define TDCGC_CMD_NVRD_BIT 2
// start option codes
`define TDCGC_OSC_OFF 3'h0
`define TDCGC_OSC_ON 3'h1
`define TDCGC_OSC_S480 3'h2
`define TDCGC_OSC_S1460 3'h3
`define TDCGC_OSC_S2440 3'h4
`define TDCGC_OSC_S5140 3'h5
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TDCGC_CLK_KHZ 20000
`define TDCGC_T480_US 480
`define TDCGC_T1460_US 1460
`define TDCGC_T2440_US 2440
`define TDCGC_T5140_US 5140
`define TDCGC_CYC(us) (((us) * `TDCGC_CLK_KHZ + 999) / 1000)
`define TDCGC_NV_WORDS 7
`define TDCGC_NV_CYC 4'h8
`define TDCGC_ERR_VALUE 32'hffffffff
`endif

// ===== logic/tdcgc_clk_div.v
/*
  high-speed reference predivider: one-cycle enable pulses at 1, 1/2, 1/4.
  assumes sys_clk is the reference clock itself.
*/
`timescale 1ns/100ps
`default_nettype none
module tdcgc_clk_div (
  input wire sysClk,
  input wire sysRst,
  input wire run,
  input wire [1:0] divSel,
  output reg divTick
);
  reg [1:0] cnt_reg;
  wire [1:0] lim;
  assign lim = (divSel == 2'h0) ? 2'h0 : (divSel == 2'h1) ? 2'h1 : 2'h3;
  always @(posedge sysClk or posedge sysRst) begin
    if (sysRst) begin
      cnt_reg <= 2'h0;
      divTick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 2'h0;
      divTick <= 1'b0;
    end else begin
      divTick <= (cnt_reg >= lim);
      cnt_reg <= (cnt_reg >= lim) ? 2'h0 : cnt_reg + 2'h1;
    end
  end
endmodule // tdcgc_clk_div
`default_nettype wire

// ===== logic/tdcgc_nvmem.v
/*
  seven-word nonvolatile store model in flip-flops, with a busy period.
  assumes single requests; a request while busy is ignored.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tdcgc_map.vh"
module tdcgc_nvmem (
  input wire sysClk,
  input wire sysRst,
  input wire wrReq,
  input wire rdReq,
  input wire [2:0] idx,
  input wire [31:0] wrData,
  output reg [31:0] rdData,
  output reg done
);
  reg [31:0] mem [0:`TDCGC_NV_WORDS-1];
  reg [3:0] busy_reg;
  reg wr_reg;
  reg [2:0] idx_reg;
  reg [31:0] dat_reg;
  integer i;
  always @(posedge sysClk or posedge sysRst) begin
    if (sysRst) begin
      for (i = 0; i < `TDCGC_NV_WORDS; i = i + 1)
        mem[i] <= 32'h0;
      busy_reg <= 4'h0;
      wr_reg <= 1'b0;
      idx_reg <= 3'h0;
      dat_reg <= 32'h0;
      rdData <= 32'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (busy_reg == 4'h0) begin
        if ((wrReq || rdReq) && idx < 3'h7) begin
          busy_reg <= `TDCGC_NV_CYC;
          wr_reg <= wrReq;
          idx_reg <= idx;
          dat_reg <= wrData;
        end
      end else begin
        busy_reg <= busy_reg - 4'h1;
        if (busy_reg == 4'h1) begin
          if (wr_reg)
            mem[idx_reg] <= dat_reg;
          else
            rdData <= mem[idx_reg];
          done <= 1'b1;
        end
      end
    end
  end
endmodule // tdcgc_nvmem
`default_nettype wire

// ===== logic/tdcgc_top.v
/*
  general configuration and interrupt logic of a time-to-digital converter.
  assumes event inputs come from logic on sys_clk; host uses a strobe port.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tdcgc_map.vh"
module tdcgc_top (
  input wire sys_clk,
  input wire sys_rst,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [31:0] regRdData,
  input wire evTimeout,
  input wire evHitsDone,
  input wire evAluDone,
  input wire [31:0] aluResult,
  output reg intrOut,
  output reg hsOscOn,
  output reg hsClkReady,
  output reg divTickOut,
  output reg lfHighCurrent,
  output reg startNoiseOn,
  output reg phaseNoiseOn,
  output reg initPulse,
  output reg [1:0] resMode,
  output reg resModeErr
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [`TDCGC_CFG_W-1:0] cfg_reg;
  reg [3:0] irqEn_reg;
  reg [3:0] pend_reg;
  reg [3:0] pend_next;
  reg [31:0] result_reg;
  reg [2:0] nvSel_reg;
  reg [31:0] nvWrData_reg;
  reg [22:0] settle_reg;
  reg settled_reg;
  reg hostInit_reg;
  wire [1:0] divSel;
  wire [2:0] oscOpt;
  wire nvDone;
  wire divTick;
  wire [31:0] nvRdData;
  wire cmdWr;
  wire [3:0] events;
  wire anyIrq;
  reg [22:0] settleLoad;
  reg [31:0] settleFull;
  assign divSel = cfg_reg[`TDCGC_DIV_LSB+1:`TDCGC_DIV_LSB];
  assign oscOpt = cfg_reg[`TDCGC_START_LSB+2:`TDCGC_START_LSB];
  assign cmdWr = regWrStb && regAddr == `TDCGC_CMD_ADDR;
  // ---------------------------------------------------------------
  // oscillator start and settling
  // ---------------------------------------------------------------
  // counts scale with the reference rate
  always @* begin
    case (oscOpt)
      `TDCGC_OSC_S480: settleFull = `TDCGC_CYC(`TDCGC_T480_US);
      `TDCGC_OSC_S1460: settleFull = `TDCGC_CYC(`TDCGC_T1460_US);
      `TDCGC_OSC_S2440: settleFull = `TDCGC_CYC(`TDCGC_T2440_US);
      `TDCGC_OSC_S5140: settleFull = `TDCGC_CYC(`TDCGC_T5140_US);
      default: settleFull = 32'h0;
    endcase
    // longest settle fits 23 bits, upper bits always zero
    settleLoad = settleFull[22:0];
  end
  // settling restarts whenever the option is rewritten
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_reg <= 23'h0;
      settled_reg <= 1'b0;
    end else if (regWrStb && regAddr == `TDCGC_CFG_ADDR) begin
      settle_reg <= 23'h0;
      settled_reg <= 1'b0;
    end else if (oscOpt == `TDCGC_OSC_ON) begin
      settled_reg <= 1'b1;
    end else if (oscOpt == `TDCGC_OSC_OFF || oscOpt > `TDCGC_OSC_S5140) begin
      settled_reg <= 1'b0;
    end else if (!settled_reg) begin
      settle_reg <= settle_reg + 23'h1;
      if (settle_reg + 23'h1 >= settleLoad)
        settled_reg <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // predivider
  // ---------------------------------------------------------------
  // divided reference enable
  tdcgc_clk_div uDiv (
    .sysClk(sys_clk),
    .sysRst(sys_rst),
    .run(settled_reg),
    .divSel(divSel),
    .divTick(divTick)
  );
  // ---------------------------------------------------------------
  // nonvolatile store
  // ---------------------------------------------------------------
  // config and ident store
  tdcgc_nvmem uNv (
    .sysClk(sys_clk),
    .sysRst(sys_rst),
    .wrReq(cmdWr && regWrData[`TDCGC_CMD_NVWR_BIT]),
    .rdReq(cmdWr && regWrData[`TDCGC_CMD_NVRD_BIT]),
    .idx(nvSel_reg),
    .wrData(nvWrData_reg),
    .rdData(nvRdData),
    .done(nvDone)
  );
  // ---------------------------------------------------------------
  // interrupt pending bits
  // ---------------------------------------------------------------
  // source events
  assign events = {nvDone, evAluDone, evHitsDone, evTimeout};
  always @* begin
    pend_next = pend_reg;
    if (regWrStb && regAddr == `TDCGC_STAT_ADDR)
      pend_next = pend_reg & ~regWrData[3:0];
    // set beats a simultaneous clear
    pend_next = pend_next | (events & irqEn_reg);
    pend_next = pend_next & irqEn_reg;
  end
  assign anyIrq = |pend_next;
  // ---------------------------------------------------------------
  // register writes and state
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg <= `TDCGC_CFG_RESET;
      irqEn_reg <= 4'h0;
      pend_reg <= 4'h0;
      result_reg <= 32'h0;
      nvSel_reg <= 3'h0;
      nvWrData_reg <= 32'h0;
      hostInit_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      hostInit_reg <= cmdWr && regWrData[`TDCGC_CMD_INIT_BIT];
      if (regWrStb && regAddr == `TDCGC_CFG_ADDR)
        cfg_reg <= regWrData[`TDCGC_CFG_W-1:0];
      if (regWrStb && regAddr == `TDCGC_IRQEN_ADDR)
        irqEn_reg <= regWrData[3:0];
      if (regWrStb && regAddr == `TDCGC_NVSEL_ADDR)
        nvSel_reg <= regWrData[2:0];
      if (regWrStb && regAddr == `TDCGC_NVDATA_ADDR)
        nvWrData_reg <= regWrData;
      if (evTimeout && cfg_reg[`TDCGC_ERRFILL_BIT])
        result_reg <= `TDCGC_ERR_VALUE;
      else if (evAluDone)
        result_reg <= aluResult;
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      intrOut <= 1'b0;
      hsOscOn <= 1'b0;
      hsClkReady <= 1'b0;
      divTickOut <= 1'b0;
      lfHighCurrent <= 1'b0;
      startNoiseOn <= 1'b0;
      phaseNoiseOn <= 1'b1;
      initPulse <= 1'b0;
      resMode <= 2'h0;
      resModeErr <= 1'b0;
    end else begin
      intrOut <= anyIrq;
      hsOscOn <= (oscOpt != `TDCGC_OSC_OFF) && (oscOpt <= `TDCGC_OSC_S5140);
      hsClkReady <= settled_reg;
      divTickOut <= divTick;
      lfHighCurrent <= cfg_reg[`TDCGC_LFHIGH_BIT];
      startNoiseOn <= cfg_reg[`TDCGC_NOISE_BIT];
      phaseNoiseOn <= !cfg_reg[`TDCGC_PHDIS_BIT];
      initPulse <= hostInit_reg ||
        (cfg_reg[`TDCGC_REINIT_BIT] && anyIrq && !intrOut);
      // resolution select, quad only in mode 2
      if (cfg_reg[`TDCGC_QUAD_BIT] && cfg_reg[`TDCGC_MODE2_BIT])
        resMode <= 2'h2;
      else if (cfg_reg[`TDCGC_DOUBLE_BIT])
        resMode <= 2'h1;
      else
        resMode <= 2'h0;
      resModeErr <= cfg_reg[`TDCGC_QUAD_BIT] && !cfg_reg[`TDCGC_MODE2_BIT];
    end
  end
  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // ident readback path
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 32'h0;
    end else if (regRdStb) begin
      case (regAddr)
        `TDCGC_CFG_ADDR: regRdData <= {19'h0, cfg_reg};
        `TDCGC_IRQEN_ADDR: regRdData <= {28'h0, irqEn_reg};
        `TDCGC_STAT_ADDR: regRdData <= {26'h0, settled_reg, intrOut, pend_reg};
        `TDCGC_RESULT_ADDR: regRdData <= result_reg;
        `TDCGC_NVSEL_ADDR: regRdData <= {29'h0, nvSel_reg};
        `TDCGC_NVDATA_ADDR: regRdData <= nvRdData;
        default: regRdData <= 32'h0;
      endcase
    end else begin
      regRdData <= 32'h0;
    end
  end
endmodule // tdcgc_top
`default_nettype wire

// ===== verification/tdcgc_monitor.sv
/*
  port checker of the tdc configuration and interrupt block.
  assumes the strobe register port and single-cycle event pulses.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tdcgc_map.vh"
module tdcgc_monitor (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic evTimeout,
  input wire logic evHitsDone,
  input wire logic evAluDone,
  input wire logic intrOut,
  input wire logic lfHighCurrent,
  input wire logic startNoiseOn,
  input wire logic phaseNoiseOn,
  input wire logic initPulse,
  input wire logic resModeErr
);
  // ---------------------------------------------
  // shadow of config and enables
  // ---------------------------------------------
  logic [12:0] cfgReg;
  logic [3:0] enReg;
  logic cfgWr;
  assign cfgWr = regWrStb && regAddr == `TDCGC_CFG_ADDR;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgReg <= 13'h0000;
      enReg <= 4'h0;
    end else if (cfgWr) begin
      cfgReg <= regWrData[12:0];
    end else if (regWrStb && regAddr == `TDCGC_IRQEN_ADDR) begin
      enReg <= regWrData[3:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_LF_CURRENT: assert property (
    cfgWr |-> ##2 lfHighCurrent == $past(regWrData[5], 2))
    else $error("low-frequency current option not applied");
  AST_START_NOISE: assert property (
    cfgWr |-> ##2 startNoiseOn == $past(regWrData[6], 2))
    else $error("start noise output wrong");
  AST_PHASE_NOISE: assert property (
    cfgWr |-> ##2 phaseNoiseOn == !$past(regWrData[7], 2))
    else $error("phase noise output wrong");
  AST_QUAD_GUARD: assert property (
    cfgWr && regWrData[10] && !regWrData[12] |-> ##2 resModeErr)
    else $error("fourfold resolution outside mode 2 not flagged");
  AST_IRQ_TIMEOUT: assert property (
    evTimeout && enReg[0] && !regWrStb |-> ##[1:2] intrOut)
    else $error("timeout interrupt missing");
  AST_IRQ_HITS: assert property (
    evHitsDone && enReg[1] && !regWrStb |-> ##[1:2] intrOut)
    else $error("hits interrupt missing");
  AST_IRQ_ALU: assert property (
    evAluDone && enReg[2] && !regWrStb |-> ##[1:2] intrOut)
    else $error("arithmetic interrupt missing");
  // three cycles lets a dropped pending bit reach the registered output
  AST_IRQ_MASKED: assert property (
    (enReg == 4'h0) [*3] |-> !intrOut)
    else $error("interrupt with all sources disabled");
  AST_REINIT: assert property (
    $rose(intrOut) && cfgReg[8] |-> ##[0:2] initPulse)
    else $error("no re-init after interrupt");
  cover property (cfgWr && regWrData[10]);
  cover property ($rose(intrOut));
  cover property (initPulse && cfgReg[8]);
endmodule // tdcgc_monitor
bind tdcgc_top tdcgc_monitor tdcgc_monitor_i (.sys_clk, .sys_rst, .regAddr,
  .regWrData, .regWrStb, .evTimeout, .evHitsDone, .evAluDone, .intrOut,
  .lfHighCurrent, .startNoiseOn, .phaseNoiseOn, .initPulse, .resModeErr);
`default_nettype wire

// ===== verification/tdcgc_host_model.sv
/*
  host controller model: drives the register port through tasks.
  assumes one master, signals changed just after the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module tdcgc_host_model (
  input wire logic sys_clk,
  output logic [7:0] regAddr,
  output logic [31:0] regWrData,
  output logic regWrStb,
  output logic regRdStb,
  input wire logic [31:0] regRdData
);
  // host knows the reference rate to scale results
  localparam int REF_KHZ = 20000;
  initial begin
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask
  // ident read back; data only valid the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    @(negedge sys_clk);
    v = regRdData;
  endtask
endmodule // tdcgc_host_model
`default_nettype wire

// ===== verification/tdc_general_config_irq_tb_top.sv
/*
  self-checking bench of the tdc configuration and interrupt block.
  assumes the host model drives the register port.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tdcgc_map.vh"
module tdc_general_config_irq_tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic evTimeout = 1'b0;
  logic evHitsDone = 1'b0;
  logic evAluDone = 1'b0;
  logic [31:0] aluResult = 32'h0;
  wire logic [7:0] regAddr;
  wire logic [31:0] regWrData, regRdData;
  wire logic regWrStb, regRdStb, intrOut, hsOscOn, hsClkReady, divTickOut;
  wire logic lfHighCurrent, startNoiseOn, phaseNoiseOn, initPulse, resModeErr;
  wire logic [1:0] resMode;
  logic [31:0] d;
  int n, i, nFail = 0, comparisons = 0;
  always #25 sys_clk = ~sys_clk;
  tdcgc_host_model tdcgc_host_model_i (.sys_clk, .regAddr, .regWrData,
    .regWrStb, .regRdStb, .regRdData);
  tdcgc_top tdcgc_top_i (.sys_clk, .sys_rst, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .evTimeout, .evHitsDone, .evAluDone, .aluResult,
    .intrOut, .hsOscOn, .hsClkReady, .divTickOut, .lfHighCurrent,
    .startNoiseOn, .phaseNoiseOn, .initPulse, .resMode, .resModeErr);
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    tdcgc_host_model_i.wr(a, v);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    tdcgc_host_model_i.rd(a, v);
  endtask
  // a write lands one cycle later and reaches the outputs one after that
  task automatic cfg(input logic [31:0] v);
    wr(`TDCGC_CFG_ADDR, v);
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic ev(input logic [2:0] m, input logic [31:0] v);
    @(posedge sys_clk);
    {evAluDone, evHitsDone, evTimeout} <= m;
    aluResult <= v;
    @(posedge sys_clk);
    {evAluDone, evHitsDone, evTimeout} <= 3'h0;
  endtask
  task automatic waitOn(input int sel, input int lim, output int k);
    for (k = 0; k < lim; k++) begin
      @(negedge sys_clk);
      if (sel == 0 && intrOut === 1'b1) return;
      if (sel == 1 && hsClkReady === 1'b1) return;
      if (sel == 2 && initPulse === 1'b1) return;
    end
    nFail++;
    printVerdict();
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    check({intrOut, hsOscOn, phaseNoiseOn, initPulse, resModeErr}, 5'h04);
    rd(`TDCGC_CFG_ADDR, d);
    check(d, 32'h0);
    rd(8'h1c, d);
    check(d, 32'h0);
    cfg(32'h0e0);
    check({lfHighCurrent, startNoiseOn, phaseNoiseOn}, 3'h6);
    cfg(32'h400);
    check(resModeErr, 1'b1);
    cfg(32'h1400);
    check({resModeErr, resMode}, 3'h2);
    cfg(32'h1800);
    check({resModeErr, resMode}, 3'h1);
    cfg(32'h800);
    check({resModeErr, resMode}, 3'h1);
    for (i = 0; i < 3; i++) begin
      cfg(32'h4 | i);
      waitOn(1, 110000, n);
      check(hsOscOn, 1'b1);
      n = 0;
      repeat (40) begin
        @(negedge sys_clk);
        n += (divTickOut === 1'b1);
      end
      check(n, 40 >> i);
    end
    cfg(32'h0);
    check({hsOscOn, hsClkReady}, 2'h0);
    wr(`TDCGC_CFG_ADDR, 32'h8);
    waitOn(1, 11000, n);
    check(n > 9590 && n < 9610, 1'b1);
    for (i = 0; i < 3; i++) begin
      wr(`TDCGC_IRQEN_ADDR, 32'h0);
      ev(3'h1 << i, 32'h0);
      repeat (3) @(negedge sys_clk);
      check(intrOut, 1'b0);
      wr(`TDCGC_IRQEN_ADDR, 32'h1 << i);
      ev(3'h1 << i, 32'h0);
      waitOn(0, 5, n);
      rd(`TDCGC_STAT_ADDR, d);
      check(d[3:0], 4'h1 << i);
      wr(`TDCGC_STAT_ADDR, 32'hf);
      repeat (2) @(negedge sys_clk);
      check(intrOut, 1'b0);
    end
    cfg(32'h200);
    ev(3'h1, 32'h12345678);
    rd(`TDCGC_RESULT_ADDR, d);
    check(d, `TDCGC_ERR_VALUE);
    cfg(32'h100);
    ev(3'h4, 32'h00c0ffee);
    waitOn(2, 6, n);
    rd(`TDCGC_RESULT_ADDR, d);
    check(d, 32'h00c0ffee);
    wr(`TDCGC_STAT_ADDR, 32'hf);
    wr(`TDCGC_CMD_ADDR, 32'h1);
    waitOn(2, 3, n);
    wr(`TDCGC_NVSEL_ADDR, 32'h6);
    wr(`TDCGC_NVDATA_ADDR, 32'h0000abcd);
    wr(`TDCGC_IRQEN_ADDR, 32'h8);
    wr(`TDCGC_CMD_ADDR, 32'h2);
    waitOn(0, 20, n);
    rd(`TDCGC_STAT_ADDR, d);
    check(d[3:0], 4'h8);
    wr(`TDCGC_STAT_ADDR, 32'hf);
    wr(`TDCGC_NVDATA_ADDR, 32'h0);
    wr(`TDCGC_CMD_ADDR, 32'h4);
    waitOn(0, 20, n);
    rd(`TDCGC_NVDATA_ADDR, d);
    check(d, 32'h0000abcd);
    printVerdict();
  end
endmodule // tdc_general_config_irq_tb_top
`default_nettype wire
